/* hdl/gls_pkg.sv */
// package for the gate switch led status and flash code block
// assumes a single 50 MHz clock and power-up reset only
//
// Operation
// - power/fault led green when ready and no fault present
// - gate led yellow while actuator is detected in range
// - lock led green while magnetic guard locking is engaged
// - input led steady yellow while both input channels are high
// - one channel falls while other high: flash input led until both low
// - on fault power/fault led red, blink code on gate or input led
// - lock led red when locking requested but not achieved
// - each blink sequence starts with three short header flashes
// - after long pause each digit flashes its count at one-second spacing
// - a fault code has one to three digits separated by long gaps
// - after last digit the header and pattern repeat while fault stays
// - flash counts 1 to 15 mean 1 to 15, sixteen flashes mean zero
// - code 1,4,1 reports input or output wiring fault
// - codes 1,12 or 1,6,3 report first safety output wiring fault
// - codes 1,13 or 1,6,4 report second safety output wiring fault
// - code 14 or 15 for first or second output wiring or load fault
// - any other code denotes an internal device fault
// - magnet energised only while lock request high and actuator detected
package gls_pkg;

    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned DIGIT_MS     = 1000;
    localparam int unsigned SHORT_MS     = 200;
    localparam int unsigned GAP_MS       = 2000;
    localparam int unsigned PAUSE_MS     = 3000;
    localparam int unsigned PARTIAL_MS   = 500;
    localparam int unsigned DIGIT_CYC    = CLK_HZ / 1000 * DIGIT_MS;
    localparam int unsigned SHORT_CYC    = CLK_HZ / 1000 * SHORT_MS;
    localparam int unsigned GAP_CYC      = CLK_HZ / 1000 * GAP_MS;
    localparam int unsigned PAUSE_CYC    = CLK_HZ / 1000 * PAUSE_MS;
    localparam int unsigned PARTIAL_CYC  = CLK_HZ / 1000 * PARTIAL_MS;
    localparam int unsigned HDR_FLASHES  = 3;
    localparam int unsigned MAX_DIGITS   = 3;
    localparam logic [4:0]  ZERO_FLASHES = 5'h10;

    // fault causes, binary encoded; priority: lowest index wins
    localparam logic [2:0] FLT_NONE    = 3'h0;
    localparam logic [2:0] FLT_WIRING  = 3'h1;
    localparam logic [2:0] FLT_OUT1    = 3'h2;
    localparam logic [2:0] FLT_OUT2    = 3'h3;
    localparam logic [2:0] FLT_OUT1_C  = 3'h4;
    localparam logic [2:0] FLT_OUT2_C  = 3'h5;
    localparam logic [2:0] FLT_INT     = 3'h6;

    typedef struct packed {
        logic wiring;
        logic out1_wiring;
        logic out2_wiring;
        logic out1_load;
        logic out2_load;
        logic internal;
    } gls_fault_t;

    // one two-colour led: green/red or yellow
    typedef struct packed {
        logic green;
        logic red;
    } gls_bicolor_t;

    typedef struct packed {
        logic [1:0]           count;
        logic [2:0][3:0]      digit;
    } gls_code_t;

    typedef enum logic [2:0] {
        BS_IDLE   = 3'b000,
        BS_HDR_ON = 3'b001,
        BS_HDR_OF = 3'b010,
        BS_PAUSE  = 3'b011,
        BS_DIG_ON = 3'b100,
        BS_DIG_OF = 3'b101,
        BS_GAP    = 3'b110
    } gls_blink_t;

endpackage : gls_pkg

/* hdl/gls_status.sv */
// led status and flash-code generator for a guard-locking gate switch
// assumes synchronous inputs, single clock, reset only at power-up
`timescale 1ns/10ps
module gls_status #(
    parameter int unsigned DIGIT_CYCLES   = gls_pkg::DIGIT_CYC,
    parameter int unsigned SHORT_CYCLES   = gls_pkg::SHORT_CYC,
    parameter int unsigned GAP_CYCLES     = gls_pkg::GAP_CYC,
    parameter int unsigned PAUSE_CYCLES   = gls_pkg::PAUSE_CYC,
    parameter int unsigned PARTIAL_CYCLES = gls_pkg::PARTIAL_CYC
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // inputs from evaluation device and sensing
    input  wire logic             input_channel_one_in,
    input  wire logic             input_channel_two_in,
    input  wire logic             lock_request_input_in,
    input  wire logic             actuator_detected_in,
    input  wire logic             lock_held_in,
    input  wire logic             ready_in,
    input  wire gls_pkg::gls_fault_t fault_in,
    input  wire logic             fault_on_input_led_in,
    // outputs
    output logic                  magnet_on_out,
    output gls_pkg::gls_bicolor_t power_led_out,
    output logic                  gate_led_out,
    output gls_pkg::gls_bicolor_t lock_led_out,
    output logic                  input_led_out,
    output logic                  fault_latched_out
);
    import gls_pkg::*;

    localparam int unsigned CW = $clog2(PAUSE_CYCLES + DIGIT_CYCLES + 1);

    function automatic gls_code_t code_of(input logic [2:0] cause);
        gls_code_t c;
        c = '0;
        unique case (cause)
            FLT_WIRING: c = '{count: 2'h3, digit: {4'h1, 4'h4, 4'h1}};
            FLT_OUT1:   c = '{count: 2'h2, digit: {4'h0, 4'hC, 4'h1}};
            FLT_OUT2:   c = '{count: 2'h2, digit: {4'h0, 4'hD, 4'h1}};
            FLT_OUT1_C: c = '{count: 2'h1, digit: {4'h0, 4'h0, 4'hE}};
            FLT_OUT2_C: c = '{count: 2'h1, digit: {4'h0, 4'h0, 4'hF}};
            default:    c = '{count: 2'h3, digit: {4'h9, 4'h9, 4'h9}};
        endcase
        return c;
    endfunction : code_of

    // zero digit is sent as sixteen flashes
    function automatic logic [4:0] flashes_of(input logic [3:0] d);
        return (d == 4'h0) ? ZERO_FLASHES : {1'b0, d};
    endfunction : flashes_of

    ////////////////////////////////////////////////////////////////////////////
    // fault latch
    logic        fault_reg;
    logic [2:0]  cause_reg;
    logic        on_input_reg;
    wire  [2:0]  cause_now = fault_in.wiring      ? FLT_WIRING :
                             fault_in.out1_wiring ? FLT_OUT1   :
                             fault_in.out2_wiring ? FLT_OUT2   :
                             fault_in.out1_load   ? FLT_OUT1_C :
                             fault_in.out2_load   ? FLT_OUT2_C :
                             fault_in.internal    ? FLT_INT    : FLT_NONE;
    wire         fault_new = !fault_reg && (cause_now != FLT_NONE);

    // only power-up clears it, so a transient fault still demands service
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_reg    <= 1'b0;
            cause_reg    <= FLT_NONE;
            on_input_reg <= 1'b0;
        end else if (fault_new) begin
            fault_reg    <= 1'b1;
            cause_reg    <= cause_now;
            on_input_reg <= fault_on_input_led_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // partial operation tracking
    logic both_prev_reg;
    logic partial_reg;
    logic [CW-1:0] pflash_cnt_reg;
    logic          pflash_reg;
    wire  both_high = input_channel_one_in && input_channel_two_in;
    wire  both_low  = !input_channel_one_in && !input_channel_two_in;
    wire  one_fell  = both_prev_reg && (input_channel_one_in ^ input_channel_two_in);
    wire  pwrap     = (pflash_cnt_reg == CW'(PARTIAL_CYCLES - 1));

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            both_prev_reg <= 1'b0;
            partial_reg   <= 1'b0;
        end else begin
            both_prev_reg <= both_high;
            if (both_low)
                partial_reg <= 1'b0;
            else if (one_fell)
                partial_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pflash_cnt_reg <= '0;
            pflash_reg     <= 1'b0;
        end else if (!partial_reg) begin
            pflash_cnt_reg <= '0;
            pflash_reg     <= 1'b0;
        end else begin
            pflash_cnt_reg <= pwrap ? '0 : pflash_cnt_reg + 1'b1;
            if (pwrap)
                pflash_reg <= !pflash_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // blink-code sequencer
    gls_blink_t      state_reg, state_next;
    logic [CW-1:0]   tmr_reg;
    logic [4:0]      flash_reg;
    logic [1:0]      didx_reg;
    gls_code_t       code;
    logic [CW-1:0]   dur;
    logic [4:0]      target;
    wire             tmr_done = (tmr_reg == dur);
    wire             blink_on = (state_reg == BS_HDR_ON) || (state_reg == BS_DIG_ON);

    assign code   = code_of(cause_reg);
    assign target = flashes_of(code.digit[didx_reg]);

    // one-second flash period split half on, half off; short flash is far shorter
    always_comb begin
        unique case (state_reg)
            BS_HDR_ON, BS_HDR_OF: dur = CW'(SHORT_CYCLES - 1);
            BS_PAUSE:             dur = CW'(PAUSE_CYCLES - 1);
            BS_GAP:               dur = CW'(GAP_CYCLES - 1);
            BS_DIG_ON, BS_DIG_OF: dur = CW'(DIGIT_CYCLES / 2 - 1);
            default:              dur = '0;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            BS_IDLE:   if (fault_reg) state_next = BS_HDR_ON;
            BS_HDR_ON: if (tmr_done) state_next = BS_HDR_OF;
            BS_HDR_OF: if (tmr_done)
                           state_next = (flash_reg == 5'(HDR_FLASHES - 1)) ? BS_PAUSE : BS_HDR_ON;
            BS_PAUSE:  if (tmr_done) state_next = BS_DIG_ON;
            BS_DIG_ON: if (tmr_done) state_next = BS_DIG_OF;
            BS_DIG_OF: if (tmr_done) begin
                           if (flash_reg != target - 5'h1)
                               state_next = BS_DIG_ON;
                           else if (didx_reg == code.count - 2'h1)
                               state_next = BS_HDR_ON;
                           else
                               state_next = BS_GAP;
                       end
            BS_GAP:    if (tmr_done) state_next = BS_DIG_ON;
            default:   state_next = BS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= BS_IDLE;
            tmr_reg   <= '0;
        end else begin
            state_reg <= state_next;
            tmr_reg   <= (state_next != state_reg) ? '0 : tmr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flash_reg <= '0;
            didx_reg  <= '0;
        end else if (state_reg == BS_IDLE || (state_next == BS_HDR_ON && state_reg == BS_DIG_OF)) begin
            flash_reg <= '0;
            didx_reg  <= '0;
        end else if (tmr_done && (state_reg == BS_HDR_OF || state_reg == BS_DIG_OF)) begin
            flash_reg <= (state_next == BS_HDR_ON || state_next == BS_DIG_ON) ? flash_reg + 5'h1 : '0;
            if (state_next == BS_GAP)
                didx_reg <= didx_reg + 2'h1;
        end else if (state_reg == BS_PAUSE || state_reg == BS_GAP) begin
            flash_reg <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    wire magnet_next = lock_request_input_in && actuator_detected_in && !fault_reg;
    wire locked      = magnet_on_out && lock_held_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            magnet_on_out     <= 1'b0;
            power_led_out     <= '0;
            gate_led_out      <= 1'b0;
            lock_led_out      <= '0;
            input_led_out     <= 1'b0;
            fault_latched_out <= 1'b0;
        end else begin
            magnet_on_out       <= magnet_next;
            power_led_out.green <= ready_in && !fault_reg;
            power_led_out.red   <= fault_reg;
            gate_led_out        <= (fault_reg && !on_input_reg) ? blink_on
                                                                : actuator_detected_in;
            lock_led_out.green  <= locked;
            lock_led_out.red    <= lock_request_input_in && !locked;
            input_led_out       <= (fault_reg && on_input_reg) ? blink_on :
                                   partial_reg ? pflash_reg : both_high;
            fault_latched_out   <= fault_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_latch;
        @(posedge clk_in) disable iff (rst_in) fault_reg |=> fault_reg;
    endproperty
    a_latch: assert property (p_latch) else $error("fault latch dropped");

    property p_red;
        @(posedge clk_in) disable iff (rst_in) fault_reg |=> power_led_out.red && !power_led_out.green;
    endproperty
    a_red: assert property (p_red) else $error("power led not red on fault");

    property p_magnet;
        @(posedge clk_in) disable iff (rst_in)
            magnet_on_out |-> $past(lock_request_input_in) && $past(actuator_detected_in);
    endproperty
    a_magnet: assert property (p_magnet) else $error("magnet on without cause");

    property p_hdr;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_PAUSE && $changed(state_reg)) |-> $past(flash_reg) == 5'(HDR_FLASHES - 1);
    endproperty
    a_hdr: assert property (p_hdr) else $error("header flash count wrong");

    property p_steady;
        @(posedge clk_in) disable iff (rst_in)
            (both_high && !partial_reg && !fault_reg) |=> input_led_out;
    endproperty
    a_steady: assert property (p_steady) else $error("input led not lit");

    property p_partial;
        @(posedge clk_in) disable iff (rst_in) one_fell |=> partial_reg;
    endproperty
    a_partial: assert property (p_partial) else $error("partial not flagged");

    property p_lockred;
        @(posedge clk_in) disable iff (rst_in)
            (lock_request_input_in && !actuator_detected_in) ##1 lock_request_input_in |=> lock_led_out.red;
    endproperty
    a_lockred: assert property (p_lockred) else $error("lock led not red");

    property p_digit;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_DIG_OF && tmr_done && flash_reg == target - 5'h1) |=> state_reg != BS_DIG_ON;
    endproperty
    a_digit: assert property (p_digit) else $error("extra digit flash");

    property p_gate;
        @(posedge clk_in) disable iff (rst_in)
            (!fault_reg && actuator_detected_in) |=> gate_led_out;
    endproperty
    a_gate: assert property (p_gate) else $error("gate led not lit");

    property p_green;
        @(posedge clk_in) disable iff (rst_in)
            (ready_in && !fault_reg) |=> power_led_out.green;
    endproperty
    a_green: assert property (p_green) else $error("power led not green when ready");

    property p_lockon;
        @(posedge clk_in) disable iff (rst_in)
            (magnet_on_out && lock_held_in) |=> lock_led_out.green;
    endproperty
    a_lockon: assert property (p_lockon) else $error("lock led not green while locked");

    property p_pflash;
        @(posedge clk_in) disable iff (rst_in)
            (partial_reg && !fault_reg) |=> input_led_out == $past(pflash_reg);
    endproperty
    a_pflash: assert property (p_pflash) else $error("input led not flashing in partial operation");

    property p_ptoggle;
        @(posedge clk_in) disable iff (rst_in)
            (partial_reg && pwrap) |=> pflash_reg != $past(pflash_reg);
    endproperty
    a_ptoggle: assert property (p_ptoggle) else $error("partial flash did not toggle");

    property p_pclear;
        @(posedge clk_in) disable iff (rst_in)
            both_low |=> !partial_reg;
    endproperty
    a_pclear: assert property (p_pclear) else $error("partial not cleared by both low");

    property p_codein;
        @(posedge clk_in) disable iff (rst_in)
            (fault_reg && on_input_reg) |=> input_led_out == $past(blink_on);
    endproperty
    a_codein: assert property (p_codein) else $error("blink code missing on input led");

    property p_codegate;
        @(posedge clk_in) disable iff (rst_in)
            (fault_reg && !on_input_reg) |=> gate_led_out == $past(blink_on);
    endproperty
    a_codegate: assert property (p_codegate) else $error("blink code missing on gate led");

    property p_start;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_IDLE && fault_reg) |=> state_reg == BS_HDR_ON;
    endproperty
    a_start: assert property (p_start) else $error("code did not start with header");

    property p_short;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_HDR_ON) |-> tmr_reg <= CW'(SHORT_CYCLES - 1);
    endproperty
    a_short: assert property (p_short) else $error("header flash too long");

    property p_digon;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_DIG_ON) |-> tmr_reg <= CW'(DIGIT_CYCLES / 2 - 1);
    endproperty
    a_digon: assert property (p_digon) else $error("digit flash too long");

    property p_ndig;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_DIG_ON || state_reg == BS_DIG_OF || state_reg == BS_GAP) |-> didx_reg < code.count;
    endproperty
    a_ndig: assert property (p_ndig) else $error("digit index past code length");

    property p_repeat;
        @(posedge clk_in) disable iff (rst_in)
            (state_reg == BS_DIG_OF && tmr_done && flash_reg == target - 5'h1 && didx_reg == code.count - 2'h1)
                |=> state_reg == BS_HDR_ON;
    endproperty
    a_repeat: assert property (p_repeat) else $error("pattern did not repeat");

    property p_nomag;
        @(posedge clk_in) disable iff (rst_in)
            fault_reg |=> !magnet_on_out;
    endproperty
    a_nomag: assert property (p_nomag) else $error("magnet on with fault latched");

    property p_cause;
        @(posedge clk_in) disable iff (rst_in)
            fault_reg |=> $stable(cause_reg);
    endproperty
    a_cause: assert property (p_cause) else $error("latched fault cause changed");

endmodule : gls_status

/* tb/gls_lock_ctl.sv */
// behavioural model of the evaluation device driving the lock request
// assumes lock_fail_in is the red bit of the lock led, seen on rising edges
`timescale 1ns/10ps
module gls_lock_ctl #(
    parameter int unsigned HOLD_CYCLES = 25,
    parameter int unsigned SLOW_CYCLES = 0,
    parameter int unsigned SETTLE_CYCLES = 2
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control and answer
    input  wire logic enable_in,
    input  wire logic lock_fail_in,
    output logic      lock_req_out
);
    int unsigned low_cnt;
    int unsigned high_cnt;
    ////////////////////////////////////////////////////////////////////////
    // slow answers only add idle time, never shorten the hold
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_req_out <= 1'b0;
            low_cnt      <= 0;
            high_cnt     <= 0;
        end else if (lock_req_out) begin
            high_cnt <= high_cnt + 1;
            // the red lock led shows briefly while the magnet pulls in, so that is no failure yet
            if ((lock_fail_in && high_cnt >= SETTLE_CYCLES) || !enable_in) begin
                lock_req_out <= 1'b0;
                low_cnt      <= 0;
            end
        end else if (low_cnt < HOLD_CYCLES + SLOW_CYCLES) begin
            low_cnt <= low_cnt + 1;
        end else if (enable_in) begin
            lock_req_out <= 1'b1;
            high_cnt     <= 0;
        end
    end
endmodule : gls_lock_ctl

/* tb/tb_top.sv */
// self-checking bench for the led status and flash code block
// assumes shortened timing parameters and the lock request model
`timescale 1ns/10ps
module tb_top;
    import gls_pkg::*;
    localparam int unsigned DIG_C = 20, SHT_C = 4, HOLD_C = 25;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ch1 = 1'b0, ch2 = 1'b0, req = 1'b0, act = 1'b0, held = 1'b0;
    logic        rdy = 1'b0, sel = 1'b0, use_ctl = 1'b0, ctl_en = 1'b0;
    logic        ctl_req, magnet, gate_led, in_led, latched;
    gls_fault_t  flt = '0;
    gls_bicolor_t pwr, lck;
    logic [31:0] seed = 32'h5F89;
    int          num_errors = 0, checked = 0, n, oth;
    string       got, e;
    int          dg[6][3] = '{'{1, 4, 1}, '{1, 12, 0}, '{1, 13, 0}, '{14, 0, 0}, '{15, 0, 0}, '{9, 9, 9}};
    int          nd[6] = '{3, 2, 2, 1, 1, 3};
    always #10 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    gls_status #(.DIGIT_CYCLES(DIG_C), .SHORT_CYCLES(SHT_C), .GAP_CYCLES(40), .PAUSE_CYCLES(60),
                 .PARTIAL_CYCLES(5)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .input_channel_one_in(ch1), .input_channel_two_in(ch2),
        .lock_request_input_in(use_ctl ? ctl_req : req), .actuator_detected_in(act), .lock_held_in(held),
        .ready_in(rdy), .fault_in(flt), .fault_on_input_led_in(sel), .magnet_on_out(magnet),
        .power_led_out(pwr), .gate_led_out(gate_led), .lock_led_out(lck), .input_led_out(in_led),
        .fault_latched_out(latched));
    gls_lock_ctl #(.HOLD_CYCLES(HOLD_C), .SLOW_CYCLES(5)) ctl (
        .clk_in(clk_in), .rst_in(rst_in), .enable_in(ctl_en), .lock_fail_in(lck.red), .lock_req_out(ctl_req));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask : cyc
    task automatic lim(input int k, input int top);
        if (k >= top) begin
            num_errors++;
            print_verdict();
        end
    endtask : lim
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic string pat(input int k);
        string s = "SSS";
        for (int i = 0; i < nd[k]; i++) begin
            s = {s, "|"};
            repeat (dg[k][i] == 0 ? 16 : dg[k][i]) s = {s, "L"};
        end
        return {s, "SSS"};
    endfunction : pat
    // tokens: S short flash, L digit flash, | long dark before a digit flash
    task automatic capture(input gls_fault_t late, output string s, output int other);
        int hi = 0, lo = 100, lob = 0, i = 0;
        logic prev = 1'b0, v;
        s = "";
        other = 0;
        repeat (900) begin
            cyc(1);
            i++;
            if (i == 3) flt = late;
            v = sel ? in_led : gate_led;
            other += int'(sel ? gate_led : in_led);
            if (v) begin
                if (!prev) lob = lo;
                hi = prev ? hi + 1 : 1;
            end else begin
                if (prev) begin
                    if (hi == DIG_C / 2 && lob > DIG_C / 2) s = {s, "|"};
                    s = {s, hi == SHT_C ? "S" : (hi == DIG_C / 2 ? "L" : "X")};
                    lo = 0;
                end
                lo++;
            end
            prev = v;
        end
    endtask : capture
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        rst_in = 1'b0;
        cyc(2);
        repeat (40) begin
            seed = lfsr(seed);
            {rdy, held, req, act} = seed[3:0];
            ch1 = seed[4];
            ch2 = seed[4];
            cyc(3);
            check("power_green", 16'(pwr.green), 16'(rdy));
            check("gate_led", 16'(gate_led), 16'(act));
            check("magnet", 16'(magnet), 16'(req & act));
            check("lock_green", 16'(lck.green), 16'(req & act & held));
            check("lock_red", 16'(lck.red), 16'(req & ~(act & held)));
            check("input_led", 16'(in_led), 16'(seed[4]));
        end
        // partial operation: flash with period of two half periods, then clear
        ch1 = 1'b1;
        ch2 = 1'b1;
        cyc(3);
        ch1 = 1'b0;
        cyc(2);
        n = 0;
        repeat (20) begin cyc(1); n += int'(in_led); end
        check("partial_flash", 16'(n), 16'h000A);
        ch2 = 1'b0;
        cyc(3);
        n = 0;
        repeat (12) begin cyc(1); n += int'(in_led); end
        check("partial_clear", 16'(n), 16'h0000);
        // failed lock, controller backs off, then a retry that holds
        {req, act, held} = 3'h0;
        use_ctl = 1'b1;
        cyc(3);
        check("lock_red_idle", 16'(lck.red), 16'h0000);
        ctl_en = 1'b1;
        n = 0;
        while (!lck.red && n < 80) begin cyc(1); n++; end
        lim(n, 80);
        n = 0;
        while (ctl_req && n < 50) begin cyc(1); n++; end
        lim(n, 50);
        cyc(3);
        check("lock_red_off", 16'(lck.red), 16'h0000);
        {act, held} = 2'h3;
        n = 3;
        while (!ctl_req && n < 200) begin cyc(1); n++; end
        lim(n, 200);
        check("retry_spacing", 16'(n >= HOLD_C), 16'h0001);
        cyc(3);
        check("magnet_retry", 16'(magnet), 16'h0001);
        check("lock_green_retry", 16'(lck.green), 16'h0001);
        use_ctl = 1'b0;
        ctl_en = 1'b0;
        // every fault cause, alternating the blink led
        for (int k = 0; k < 6; k++) begin
            rst_in = 1'b1;
            {flt, act, ch1, ch2, rdy, req} = '0;
            sel = k[0];
            cyc(2);
            rst_in = 1'b0;
            rdy = 1'b1;
            req = 1'b1;
            cyc(2);
            flt = gls_fault_t'(6'h20 >> k);
            // a later, higher priority cause must not replace the first
            capture(k == 5 ? gls_fault_t'(6'h21) : flt, got, oth);
            e = pat(k);
            check("blink_code", 16'(got.substr(0, e.len() - 1) == e), 16'h0001);
            check("code_table", 16'(got.substr(0, e.len() - 1) == e), 16'h0001);
            check("other_led", 16'(oth), 16'h0000);
            check("power_red", 16'({pwr.red, pwr.green}), 16'h0002);
            flt = '0;
            act = 1'b1;
            cyc(4);
            check("still_latched", 16'({latched, pwr.red, magnet}), 16'h0006);
        end
        print_verdict();
    end
endmodule : tb_top
